// ### hdl/lane_flag_pkg.sv
/*
 * Constants for the per-lane status flag bank: register indices,
 * field positions, reset values and multifunction pin encodings.
 * Assumes a 16-bit register word and four lanes, A in bit 0.
 */
package lane_flag_pkg;

	// ------------------------------------------------------------
	// Register indices on the management read port
	// ------------------------------------------------------------
	localparam int          ADDR_W               = 5;
	localparam int          DATA_W               = 16;
	localparam int          LANES                = 4;
	localparam logic [4:0]  LANE_EVENT_STATUS_IX = 5'h16;
	localparam logic [4:0]  LANE_SYNC_STATUS_IX  = 5'h17;
	localparam logic [4:0]  CLOCK_COMP_STATUS_IX = 5'h18;

	// ------------------------------------------------------------
	// Field low bits, lane A at the low end of each nibble
	// ------------------------------------------------------------
	localparam int          EVT_TX_COLL_LSB      = 12;
	localparam int          EVT_DECODE_LSB       = 8;
	localparam int          EVT_PRBS_OK_LSB      = 4;
	localparam int          EVT_LOS_LSB          = 0;
	localparam int          SYNC_ALIGN_BIT       = 4;
	localparam int          SYNC_RX_COLL_LSB     = 0;
	localparam int          CTC_DROP_LSB         = 12;
	localparam int          CTC_INSERT_LSB       = 8;
	localparam int          CTC_OVF_LSB          = 4;
	localparam int          CTC_UNF_LSB          = 0;

	// ------------------------------------------------------------
	// Reset values and pin select codes
	// ------------------------------------------------------------
	localparam logic [3:0]  STICKY_RST           = 4'h0;
	localparam logic [3:0]  PASS_RST             = 4'hf;
	localparam logic        ALIGN_RST            = 1'h0;
	localparam logic        IO_STYLE_RST         = 1'h1;
	localparam logic [15:0] UNMAPPED_DATA        = 16'h0000;
	localparam logic [1:0]  MFP_SEL_IO_STYLE     = 2'h0;
	localparam logic [1:0]  MFP_SEL_COMMA        = 2'h1;
	localparam logic [1:0]  MFP_SEL_LOS          = 2'h2;
	localparam logic [1:0]  MFP_SEL_PASS         = 2'h3;

endpackage : lane_flag_pkg

// ### hdl/lane_status_flag_bank.sv
/*
 * Per-lane status flag bank: three read-only 16-bit status registers
 * holding sticky event flags of a four-lane transceiver, plus the
 * per-lane multifunction pin selection.
 * Assumes event strobes come from logic on SYS_CLK (one cycle each,
 * level also accepted) and that the management engine presents one
 * read strobe per register read on SYS_CLK.
 * Pin selects and comma levels come from logic on SYS_CLK as well;
 * the I/O style sense is a pad level and is synchronised here.
 * A read returns the flags as they stood before its clearing edge,
 * so an event that lands on that edge shows on the following read.
 * Reads of unmapped indices answer zero and clear nothing.
 * The pin output trails its source flag by one cycle.
 */
// Functional notes
// [R1] Transmit FIFO collision flags set, clear on read
// [R2] Decode or disparity error flags, clear on read
// [R3] Pattern pass bits default one, drop on error
// [R4] Reading a dropped pass bit restores one
// [R5] Loss-of-signal flags latch, default zero, read-clear
// [R6] Sync register bits fifteen to five read zero
// [R7] Deskew realign flag latches, clears on read
// [R8] Receive FIFO collision flags latch, read-clear
// [R9] Idle column removed flags, clear on read
// [R10] Idle column added flags, clear on read
// [R11] Elastic FIFO overflow flags, clear on read
// [R12] Elastic FIFO underflow flags, clear on read
// [R13] Pin select shows loss or pass bit
// [R14] Event in clearing read cycle stays set
`timescale 1ns/1ps

module lane_status_flag_bank #(
	parameter int LANES = lane_flag_pkg::LANES
) (
	// Clock and reset
	input  wire logic                       SYS_CLK,
	input  wire logic                       RST,
	// Management read port
	input  wire logic                       RD_STB,
	input  wire logic [lane_flag_pkg::ADDR_W-1:0] RD_ADDR,
	output logic      [lane_flag_pkg::DATA_W-1:0] RD_DATA,
	output logic                            RD_VALID,
	// Event strobes, per lane with lane A in bit 0, except the one shared realign strobe
	input  wire logic [LANES-1:0]           TX_FIFO_COLL,
	input  wire logic [LANES-1:0]           DECODE_ERR,
	input  wire logic [LANES-1:0]           PATTERN_ERR,
	input  wire logic [LANES-1:0]           LOS_EVT,
	input  wire logic                       DESKEW_REALIGN,
	input  wire logic [LANES-1:0]           RX_FIFO_COLL,
	input  wire logic [LANES-1:0]           IDLE_DROP,
	input  wire logic [LANES-1:0]           IDLE_INSERT,
	input  wire logic [LANES-1:0]           ELASTIC_OVF,
	input  wire logic [LANES-1:0]           ELASTIC_UNF,
	// Multifunction pin sources and selects
	input  wire logic [2*LANES-1:0]         MFP_SEL,
	input  wire logic                       HSTL_MODE,
	input  wire logic [LANES-1:0]           COMMA_DET,
	output logic      [LANES-1:0]           MULTIFUNCTION_PIN
);

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------

	// One-hot selects; a read strobe to any other index only answers
	// and leaves every flag as it was
	wire logic rd_event;
	wire logic rd_sync;
	wire logic rd_ctc;

	assign rd_event = RD_STB && (RD_ADDR == lane_flag_pkg::LANE_EVENT_STATUS_IX);
	assign rd_sync  = RD_STB && (RD_ADDR == lane_flag_pkg::LANE_SYNC_STATUS_IX);
	assign rd_ctc   = RD_STB && (RD_ADDR == lane_flag_pkg::CLOCK_COMP_STATUS_IX);

	// ------------------------------------------------------------
	// Flag storage
	// ------------------------------------------------------------

	// Sticky flags, one bit per lane, lane A in bit 0
	logic [LANES-1:0] tx_coll_q;
	logic [LANES-1:0] tx_coll_d;
	logic [LANES-1:0] decode_q;
	logic [LANES-1:0] decode_d;
	logic [LANES-1:0] pattern_check_ok_flag_q;
	logic [LANES-1:0] pattern_check_ok_flag_d;
	logic [LANES-1:0] los_q;
	logic [LANES-1:0] los_d;
	logic [LANES-1:0] rx_coll_q;
	logic [LANES-1:0] rx_coll_d;
	logic [LANES-1:0] drop_q;
	logic [LANES-1:0] drop_d;
	logic [LANES-1:0] insert_q;
	logic [LANES-1:0] insert_d;
	logic [LANES-1:0] ovf_q;
	logic [LANES-1:0] ovf_d;
	logic [LANES-1:0] unf_q;
	logic [LANES-1:0] unf_d;
	wire logic [LANES-1:0] mfp_d;

	// Alignment is one flag shared by all lanes
	logic             align_q;
	logic             align_d;

	// ------------------------------------------------------------
	// I/O style sense capture
	// ------------------------------------------------------------

	// The style sense is a pad level, not a SYS_CLK signal; three
	// flops take it in and a change only counts once the last two
	// agree, so a slow or noisy edge never reaches the pin select
	logic             hstl_meta_q;
	logic             hstl_mid_q;
	logic             hstl_late_q;
	logic             hstl_level_q;
	logic             hstl_level_d;

	// Level moves only when the last two stages agree
	assign hstl_level_d = (hstl_mid_q == hstl_late_q) ? hstl_late_q
	                                                   : hstl_level_q;

	// Only the second stage reads the first; reset to the default style
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			hstl_meta_q  <= lane_flag_pkg::IO_STYLE_RST;
			hstl_mid_q   <= lane_flag_pkg::IO_STYLE_RST;
			hstl_late_q  <= lane_flag_pkg::IO_STYLE_RST;
			hstl_level_q <= lane_flag_pkg::IO_STYLE_RST;
		end else begin
			hstl_meta_q  <= HSTL_MODE;
			hstl_mid_q   <= hstl_meta_q;
			hstl_late_q  <= hstl_mid_q;
			hstl_level_q <= hstl_level_d;
		end
	end

	// ------------------------------------------------------------
	// Lane event status next values
	// ------------------------------------------------------------

	// A new event is ORed after the clear so a colliding read keeps it;
	// the read still returns the old image, so that event shows on the
	// next read of the register instead of being lost
	genvar ln;
	generate
		for (ln = 0; ln < LANES; ln++) begin : g_lane
			// [R1] transmit collision sticky
			// [R14] set beats clear
			assign tx_coll_d[ln] = TX_FIFO_COLL[ln]
			                       | (tx_coll_q[ln] & ~rd_event);
			// [R2] decode error sticky
			assign decode_d[ln]  = DECODE_ERR[ln]
			                       | (decode_q[ln] & ~rd_event);
			// Error in the read cycle wins and shows on the next read
			// [R3] pass drops on error
			// [R4] read restores pass
			assign pattern_check_ok_flag_d[ln] =
				PATTERN_ERR[ln] ? 1'b0 :
				(rd_event ? 1'b1 : pattern_check_ok_flag_q[ln]);
			// [R5] loss-of-signal sticky
			assign los_d[ln]     = LOS_EVT[ln] | (los_q[ln] & ~rd_event);

			// Cleared by a read of the sync register
			// [R8] receive collision sticky
			assign rx_coll_d[ln] = RX_FIFO_COLL[ln]
			                       | (rx_coll_q[ln] & ~rd_sync);

			// Cleared by a clock compensation read
			// [R9] idle removed sticky
			assign drop_d[ln]    = IDLE_DROP[ln] | (drop_q[ln] & ~rd_ctc);
			// [R10] idle added sticky
			assign insert_d[ln]  = IDLE_INSERT[ln]
			                       | (insert_q[ln] & ~rd_ctc);
			// [R11] overflow sticky
			assign ovf_d[ln]     = ELASTIC_OVF[ln] | (ovf_q[ln] & ~rd_ctc);
			// [R12] underflow sticky
			assign unf_d[ln]     = ELASTIC_UNF[ln] | (unf_q[ln] & ~rd_ctc);

			// [R13] pin select decode
			wire logic [1:0] sel;
			wire logic       show_los;
			wire logic       show_pass;
			wire logic       show_comma;
			assign sel        = MFP_SEL[2*ln +: 2];
			assign show_los   = (sel == lane_flag_pkg::MFP_SEL_LOS);
			assign show_pass  = (sel == lane_flag_pkg::MFP_SEL_PASS);
			assign show_comma = (sel == lane_flag_pkg::MFP_SEL_COMMA);
			// [R13] select loss, pass, comma or I/O style level
			assign mfp_d[ln]  =
				show_los   ? los_q[ln] :
				show_pass  ? pattern_check_ok_flag_q[ln] :
				show_comma ? COMMA_DET[ln] :
				hstl_level_q;
		end
	endgenerate

	// [R7] realign flag sticky
	assign align_d = DESKEW_REALIGN | (align_q & ~rd_sync);

	// ------------------------------------------------------------
	// Flag registers
	// ------------------------------------------------------------

	// Pass bits reset to one; every other flag resets clear
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			tx_coll_q               <= lane_flag_pkg::STICKY_RST;
			decode_q                <= lane_flag_pkg::STICKY_RST;
			pattern_check_ok_flag_q <= lane_flag_pkg::PASS_RST;
			los_q                   <= lane_flag_pkg::STICKY_RST;
		end else begin
			tx_coll_q               <= tx_coll_d;
			decode_q                <= decode_d;
			pattern_check_ok_flag_q <= pattern_check_ok_flag_d;
			los_q                   <= los_d;
		end
	end

	// Synchronization and clock compensation flags
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			rx_coll_q <= lane_flag_pkg::STICKY_RST;
			align_q   <= lane_flag_pkg::ALIGN_RST;
			drop_q    <= lane_flag_pkg::STICKY_RST;
			insert_q  <= lane_flag_pkg::STICKY_RST;
			ovf_q     <= lane_flag_pkg::STICKY_RST;
			unf_q     <= lane_flag_pkg::STICKY_RST;
		end else begin
			rx_coll_q <= rx_coll_d;
			align_q   <= align_d;
			drop_q    <= drop_d;
			insert_q  <= insert_d;
			ovf_q     <= ovf_d;
			unf_q     <= unf_d;
		end
	end

	// ------------------------------------------------------------
	// Read data assembly
	// ------------------------------------------------------------

	// Images built from the values before the clearing edge
	// Each lane nibble is padded to the word width before it is shifted
	wire logic [lane_flag_pkg::DATA_W-1:0] event_word;
	wire logic [lane_flag_pkg::DATA_W-1:0] sync_word;
	wire logic [lane_flag_pkg::DATA_W-1:0] ctc_word;
	wire logic [lane_flag_pkg::DATA_W-1:0] rd_data_d;

	assign event_word = lane_flag_pkg::DATA_W'(
		  ({12'h000, tx_coll_q} << lane_flag_pkg::EVT_TX_COLL_LSB)
		| ({12'h000, decode_q}  << lane_flag_pkg::EVT_DECODE_LSB)
		| ({12'h000, pattern_check_ok_flag_q}
		                        << lane_flag_pkg::EVT_PRBS_OK_LSB)
		| ({12'h000, los_q}     << lane_flag_pkg::EVT_LOS_LSB));

	// Alignment bit sits just above the lane nibble
	// [R6] reserved reads zero
	assign sync_word = lane_flag_pkg::DATA_W'(
		  ({15'h0000, align_q}  << lane_flag_pkg::SYNC_ALIGN_BIT)
		| ({12'h000, rx_coll_q} << lane_flag_pkg::SYNC_RX_COLL_LSB));

	assign ctc_word = lane_flag_pkg::DATA_W'(
		  ({12'h000, drop_q}   << lane_flag_pkg::CTC_DROP_LSB)
		| ({12'h000, insert_q} << lane_flag_pkg::CTC_INSERT_LSB)
		| ({12'h000, ovf_q}    << lane_flag_pkg::CTC_OVF_LSB)
		| ({12'h000, unf_q}    << lane_flag_pkg::CTC_UNF_LSB));

	// Unmapped indices answer with zero rather than stalling the engine
	assign rd_data_d = rd_event ? event_word :
	                   rd_sync  ? sync_word  :
	                   rd_ctc   ? ctc_word   :
	                   lane_flag_pkg::UNMAPPED_DATA;

	// Valid pulses once per strobe, unmapped indices included
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RD_VALID <= 1'b0;
		end else begin
			RD_VALID <= RD_STB;
		end
	end

	// Data held until the next strobe so a slow serialiser can shift it
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			RD_DATA <= lane_flag_pkg::UNMAPPED_DATA;
		end else if (RD_STB) begin
			RD_DATA <= rd_data_d;
		end
	end

	// ------------------------------------------------------------
	// Multifunction pin
	// ------------------------------------------------------------

	// Pin shows the stored flag, so it lags the event by two cycles;
	// registered so the pad sees no decode glitches, and low in reset
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			MULTIFUNCTION_PIN <= '0;
		end else begin
			MULTIFUNCTION_PIN <= mfp_d;
		end
	end

endmodule : lane_status_flag_bank

// ### verif/lane_status_flag_bank_monitor.sv
/* Port assertions for the lane status flag bank.
   Assumes it is bound to the top module; one clock domain. */
`timescale 1ns/1ps
module lane_status_flag_bank_monitor #(
	parameter int LANES = 4
) (
	// Clock, reset and read port
	input wire logic               SYS_CLK,
	input wire logic               RST,
	input wire logic               RD_STB,
	input wire logic [4:0]         RD_ADDR,
	input wire logic [15:0]        RD_DATA,
	// Event strobes and pin
	input wire logic [LANES-1:0]   TX_FIFO_COLL,
	input wire logic [LANES-1:0]   PATTERN_ERR,
	input wire logic [LANES-1:0]   LOS_EVT,
	input wire logic               DESKEW_REALIGN,
	input wire logic [LANES-1:0]   RX_FIFO_COLL,
	input wire logic [2*LANES-1:0] MFP_SEL,
	input wire logic [LANES-1:0]   MULTIFUNCTION_PIN
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// One read taken at this edge
	sequence rd(a);
		RD_STB && RD_ADDR == a;
	endsequence
	sync_reserved_a: assert property (rd(5'h17) |=> RD_DATA[15:5] == 0)
		else $error("Sync register upper bits not zero");
	tx_coll_a: assert property (TX_FIFO_COLL[3] ##1 rd(5'h16) |=> RD_DATA[15])
		else $error("Lane D transmit collision flag missing");
	los_latch_a: assert property (LOS_EVT[0] ##1 rd(5'h16) |=> RD_DATA[0])
		else $error("Lane A loss flag missing");
	pass_drop_a: assert property (PATTERN_ERR[1] ##1 rd(5'h16) |=> !RD_DATA[5])
		else $error("Lane B pass bit did not drop");
	pass_restore_a: assert property (
		(rd(5'h16) ##0 PATTERN_ERR == 0) ##1 rd(5'h16)
		|=> RD_DATA[7:4] == 4'hf)
		else $error("Pass bits not restored");
	sync_clear_a: assert property (
		(rd(5'h17) ##0 (RX_FIFO_COLL == 0 && !DESKEW_REALIGN))
		##1 rd(5'h17) |=> RD_DATA[4:0] == 0)
		else $error("Sync flags not cleared by read");
	pin_los_a: assert property (LOS_EVT[0] ##1 MFP_SEL[1:0] == 2'h2
		|=> MULTIFUNCTION_PIN[0]) else $error("Pin does not show loss flag");
	pin_pass_a: assert property (PATTERN_ERR[1] ##1 MFP_SEL[3:2] == 2'h3
		|=> !MULTIFUNCTION_PIN[1]) else $error("Pin does not show pass bit");
endmodule : lane_status_flag_bank_monitor

// ### verif/mgmt_station_model.sv
/* Management station model issuing register reads on the strobe port.
   Assumes calls start just after a clock edge. */
`timescale 1ns/1ps
module mgmt_station_model (
	input  wire logic        clk,
	input  wire logic [15:0] rd_data,
	output logic             rd_stb,
	output logic [4:0]       rd_addr
);
	initial begin
		rd_stb = 1'b0;
		rd_addr = 5'h00;
	end
	// Two reads back to back; idle address inverted so nothing stale helps
	task automatic rd(input logic [4:0] a, output logic [15:0] d1,
		output logic [15:0] d2);
		rd_stb = 1'b1;
		rd_addr = a;
		@(posedge clk);
		#1;
		d1 = rd_data;
		@(posedge clk);
		#1;
		rd_stb = 1'b0;
		rd_addr = ~a;
		d2 = rd_data;
		@(posedge clk);
		#1;
	endtask : rd
endmodule : mgmt_station_model

// ### verif/lane_status_flag_bank_bench.sv
/* Self-checking bench for the lane status flag bank.
   Assumes the design and the station model are compiled first. */
`timescale 1ns/1ps
module lane_status_flag_bank_bench;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  tx, dec, pat, los, rxc, drp, ins, ovf, unf;
	logic        deskew, hstl = 1'b1;
	logic [3:0]  comma = 4'h8;
	logic [7:0]  sel = 8'h4e;
	logic        rd_stb, rd_valid;
	logic [4:0]  rd_addr;
	logic [15:0] rd_data, d1, d2;
	logic [3:0]  pin;
	int          err_count = 0;
	int          n_tests = 0;
	always #2.5 sys_clk = ~sys_clk;
	mgmt_station_model host (.clk(sys_clk), .rd_data, .rd_stb, .rd_addr);
	lane_status_flag_bank #(.LANES(4)) dut (.SYS_CLK(sys_clk), .RST(rst),
		.RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .TX_FIFO_COLL(tx), .DECODE_ERR(dec),
		.PATTERN_ERR(pat), .LOS_EVT(los), .DESKEW_REALIGN(deskew),
		.RX_FIFO_COLL(rxc), .IDLE_DROP(drp), .IDLE_INSERT(ins),
		.ELASTIC_OVF(ovf), .ELASTIC_UNF(unf), .MFP_SEL(sel),
		.HSTL_MODE(hstl), .COMMA_DET(comma), .MULTIFUNCTION_PIN(pin));
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Events sampled at the coming edge, then all dropped
	task automatic fire();
		@(posedge sys_clk);
		#1;
		{tx, dec, pat, los, rxc, drp, ins, ovf, unf, deskew} = '0;
	endtask : fire
	task automatic rdchk(input string w, input logic [4:0] a,
		input logic [15:0] e1, e2);
		logic v;
		// Valid is sampled after the first edge of the read pair
		fork
			host.rd(a, d1, d2);
			begin
				@(posedge sys_clk);
				#1;
				v = rd_valid;
			end
		join
		check(w, d1, e1);
		check(w, d2, e2);
		check("read valid", {15'h0000, v}, 16'h0001);
		check("valid idle", {15'h0000, rd_valid}, 16'h0000);
	endtask : rdchk
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		{tx, dec, pat, los, rxc, drp, ins, ovf, unf, deskew} = '0;
		repeat (4) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		rdchk("event reg", 5'h16, 16'h00f0, 16'h00f0);
		rdchk("sync reg", 5'h17, 16'h0000, 16'h0000);
		rdchk("ctc reg", 5'h18, 16'h0000, 16'h0000);
		rdchk("unmapped", 5'h1f, 16'h0000, 16'h0000);
		$display("reset image test done");
		{tx, dec, pat, los, rxc, deskew} = {16'h8421, 4'h5, 1'b1};
		{drp, ins, ovf, unf} = 16'h96a3;
		fire();
		rdchk("event reg", 5'h16, 16'h84d1, 16'h00f0);
		rdchk("sync reg", 5'h17, 16'h0015, 16'h0000);
		rdchk("ctc reg", 5'h18, 16'h96a3, 16'h0000);
		$display("event latch test done");
		// Event lands on the clearing edge and must survive
		{deskew, rxc} = 5'h12;
		fork
			host.rd(5'h17, d1, d2);
			fire();
		join
		check("sync race", d1, 16'h0000);
		check("sync race", d2, 16'h0012);
		$display("read race test done");
		check("pin idle", {12'h000, pin}, 16'h000e);
		{los, pat} = 8'h12;
		fire();
		@(posedge sys_clk);
		#1;
		check("pin event", {12'h000, pin}, 16'h000d);
		rdchk("event reg", 5'h16, 16'h00d1, 16'h00f0);
		check("pin cleared", {12'h000, pin}, 16'h000e);
		$display("pin test done");
		give_verdict();
	end
	initial begin
		#(5 * 400);
		err_count++;
		give_verdict();
	end
endmodule : lane_status_flag_bank_bench

bind lane_status_flag_bank lane_status_flag_bank_monitor #(.LANES(LANES)) mon (
	.SYS_CLK, .RST, .RD_STB, .RD_ADDR, .RD_DATA, .TX_FIFO_COLL, .PATTERN_ERR,
	.LOS_EVT, .DESKEW_REALIGN, .RX_FIFO_COLL, .MFP_SEL, .MULTIFUNCTION_PIN);
